// file: ccsu_pkg.sv
package ccsu_pkg;
	// ************************************************************
	// Command codes.
	// ************************************************************
	localparam logic [3:0] CMD_NONE   = 4'h0;
	localparam logic [3:0] CMD_RECALL = 4'h1;
	localparam logic [3:0] CMD_SAVE   = 4'h2;
	localparam logic [3:0] CMD_SRMASK = 4'h3;
	localparam logic [3:0] CMD_STBQ   = 4'h4;
	localparam logic [3:0] CMD_TRIG   = 4'h5;
	localparam logic [3:0] CMD_TEST   = 4'h6;
	localparam logic [3:0] CMD_WAIT   = 4'h7;
	localparam logic [3:0] CMD_DEFLT  = 4'h8;
	localparam logic [3:0] CMD_CLEAR  = 4'h9;
	localparam logic [3:0] CMD_PSC    = 4'hA;
	localparam logic [3:0] CMD_EVMASK = 4'hB;
	// ************************************************************
	// Status byte bit positions.
	// ************************************************************
	localparam int STB_OPERATION_SUMMARY_BIT = 7;
	localparam int STB_MSS  = 6;
	localparam int STB_ESB  = 5;
	localparam int STB_MAV  = 4;
	localparam int STB_QUESTIONABLE_SUMMARY_BIT = 3;
	// ************************************************************
	// Instrument state layout and factory defaults.
	// ************************************************************
	localparam int STATE_W  = 64;
	localparam int CAL_BIT  = 0;
	localparam int PTS_LSB  = 16;
	localparam int TINT_LSB = 32;
	localparam int ACQ_LSB  = 48;
	localparam int DEL_LSB  = 56;
	localparam logic [15:0] DEF_POINTS  = 16'h0800; // 2048 points.
	localparam logic [15:0] DEF_TINT_NS = 16'h3CF0; // 15.6 us as 15600 ns.
	localparam logic [7:0]  DEF_ACQ_CNT = 8'h01;    // Trigger counts of 1.
	localparam logic [7:0]  DEF_DELAY   = 8'h08;    // 0.08 s in 10 ms units.
	localparam logic [STATE_W-1:0] DEF_STATE =
		{DEF_DELAY, DEF_ACQ_CNT, DEF_TINT_NS, DEF_POINTS, 16'h0000};
	localparam int NUM_SLOTS = 4;
endpackage

// file: ccsu_slots.sv
`timescale 1ns/100ps
// State storage slots, written by save and read by recall.
module ccsu_slots
	import ccsu_pkg::*;
#(
	parameter int W = STATE_W,
	parameter int N = NUM_SLOTS
) (
	input  wire logic         clk,
	input  wire logic [1:0]   wr_idx,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	input  wire logic [1:0]   rd_idx,
	output logic      [W-1:0] rd_data
);
	// The slot argument is two bits wide, so exactly four slots are served.
	if (N != 4 || W < 1) begin : g_bad_slots
		$error("four slots of nonzero width are required");
	end
	logic [W-1:0] mem [N];
	// Slot write on save.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end
	assign rd_data = mem[rd_idx];
	// A saved state must be found in its slot one cycle later.
	a_slot_write: assert property (@(posedge clk)
		wr_en |=> mem[$past(wr_idx)] == $past(wr_data))
		else $error("slot write lost");
endmodule // ccsu_slots

// file: common_command_status_unit.sv
`timescale 1ns/100ps
module common_command_status_unit
	import ccsu_pkg::*;
(
	input  wire logic               CORE_CLK,
	input  wire logic               RESET_N,
	input  wire logic               CMD_VALID,
	input  wire logic [3:0]         CMD_CODE,
	input  wire logic [7:0]         CMD_ARG,
	output logic                    CMD_READY,
	input  wire logic               DEVICE_CLEAR,
	input  wire logic               SERIAL_POLL,
	output logic [7:0]              POLL_DATA,
	output logic                    SRQ,
	output logic [7:0]              QUERY_DATA,
	output logic                    QUERY_VALID,
	input  wire logic               OPERATION_SUMMARY_BIT_SUMMARY,
	input  wire logic               QUESTIONABLE_SUMMARY_BIT_SUMMARY,
	input  wire logic [7:0]         STD_EVENTS,
	input  wire logic               OUTPUT_QUEUE_EMPTY,
	input  wire logic               PENDING_BUSY,
	input  wire logic               TRIG_SOURCE_BUS,
	output logic                    TRIGGER_PULSE,
	output logic                    ABORT_PULSE,
	input  wire logic               POWER_ON_RECALL0,
	input  wire logic [7:0]         NV_SR_MASK,
	input  wire logic [7:0]         NV_EV_MASK,
	output logic                    NV_MASK_WRITE,
	input  wire logic               SELF_TEST_FAIL,
	output logic                    ERROR_PUSH,
	input  wire logic [STATE_W-1:0] LIVE_STATE,
	output logic [STATE_W-1:0]      STATE_OUT,
	output logic                    STATE_LOAD,
	output logic [7:0]              SERVICE_MASK,
	output logic                    POWER_ON_CLEAR
);
	// ************************************************************
	// Command sequencing.
	// ************************************************************
	typedef enum logic [2:0] {
		S_BOOT = 3'b001,
		S_RUN  = 3'b010,
		S_WAIT = 3'b100
	} seq_e;
	seq_e seq;
	seq_e next_seq;
	logic [7:0] ev_mask;
	logic       master_summary_bit;
	logic       mss_d;
	logic       service_requested_flag;
	logic       message_available_flag;
	logic       boot_recall;
	logic [1:0] rd_idx;
	logic [STATE_W-1:0] slot_data;
	logic       cmd;
	// A command is taken only while running, never during a wait.
	assign CMD_READY = (seq == S_RUN);
	assign cmd       = CMD_VALID && CMD_READY;
	// Next sequencer state.
	always_comb begin
		next_seq = seq;
		case (seq)
			S_BOOT: next_seq = S_RUN;
			S_RUN: begin
				if (cmd && CMD_CODE == CMD_WAIT) next_seq = S_WAIT;
			end
			S_WAIT: begin
				if (DEVICE_CLEAR || !PENDING_BUSY) next_seq = S_RUN;
			end
			default: next_seq = S_RUN;
		endcase
	end
	// Sequencer register.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			seq <= S_BOOT;
		end else begin
			seq <= next_seq;
		end
	end
	// ************************************************************
	// State slots and recall.
	// ************************************************************
	assign rd_idx = (seq == S_BOOT) ? 2'd0 : CMD_ARG[1:0];
	ccsu_slots #(.W(STATE_W), .N(NUM_SLOTS)) u_slots (
		.clk     (CORE_CLK),
		.wr_idx  (CMD_ARG[1:0]),
		.wr_en   (cmd && CMD_CODE == CMD_SAVE),
		.wr_data (LIVE_STATE),
		.rd_idx  (rd_idx),
		.rd_data (slot_data)
	);
	assign boot_recall = (seq == S_BOOT) && POWER_ON_RECALL0;
	// State load for recall, power-on recall and defaults.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			STATE_OUT  <= DEF_STATE;
			STATE_LOAD <= 1'b0;
		end else begin
			STATE_LOAD <= 1'b0;
			if (boot_recall || (cmd && CMD_CODE == CMD_RECALL)) begin
				STATE_OUT          <= slot_data;
				STATE_OUT[CAL_BIT] <= 1'b0;
				STATE_LOAD         <= 1'b1;
			end else if (cmd && CMD_CODE == CMD_DEFLT) begin
				STATE_OUT  <= DEF_STATE;
				STATE_LOAD <= 1'b1;
			end
		end
	end
	// Trigger abort, bus trigger, self-test error push.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ABORT_PULSE   <= 1'b0;
			TRIGGER_PULSE <= 1'b0;
			ERROR_PUSH    <= 1'b0;
		end else begin
			ABORT_PULSE   <= boot_recall || (cmd && (CMD_CODE == CMD_RECALL || CMD_CODE == CMD_DEFLT));
			TRIGGER_PULSE <= cmd && CMD_CODE == CMD_TRIG && TRIG_SOURCE_BUS;
			ERROR_PUSH    <= cmd && CMD_CODE == CMD_TEST && SELF_TEST_FAIL;
		end
	end
	// ************************************************************
	// Masks and power-on clear setting.
	// ************************************************************
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			POWER_ON_CLEAR <= 1'b1;
		end else if (cmd && CMD_CODE == CMD_PSC) begin
			POWER_ON_CLEAR <= CMD_ARG[0];
		end
	end
	// Masks cleared at power-on, as reset sets power-on clear, then written by commands.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SERVICE_MASK  <= 8'h00;
			ev_mask       <= 8'h00;
			NV_MASK_WRITE <= 1'b0;
		end else begin
			NV_MASK_WRITE <= 1'b0;
			if (seq == S_BOOT) begin
				SERVICE_MASK <= POWER_ON_CLEAR ? 8'h00 : NV_SR_MASK;
				ev_mask      <= POWER_ON_CLEAR ? 8'h00 : NV_EV_MASK;
			end else if (cmd && CMD_CODE == CMD_SRMASK) begin
				SERVICE_MASK  <= CMD_ARG;
				NV_MASK_WRITE <= !POWER_ON_CLEAR;
			end else if (cmd && CMD_CODE == CMD_EVMASK) begin
				ev_mask       <= CMD_ARG;
				NV_MASK_WRITE <= !POWER_ON_CLEAR;
			end
		end
	end
	// ************************************************************
	// Status byte, master summary and service request.
	// ************************************************************
	logic [7:0] stb;
	logic       event_summary_bit;
	assign event_summary_bit = |(STD_EVENTS & ev_mask);
	// Summary inputs follow their event registers; bits 2..0 are zero.
	always_comb begin
		stb           = 8'h00;
		stb[STB_OPERATION_SUMMARY_BIT] = OPERATION_SUMMARY_BIT_SUMMARY;
		stb[STB_ESB]  = event_summary_bit;
		stb[STB_MAV]  = message_available_flag;
		stb[STB_QUESTIONABLE_SUMMARY_BIT] = QUESTIONABLE_SUMMARY_BIT_SUMMARY;
		stb[STB_MSS]  = master_summary_bit;
	end
	assign master_summary_bit = |({OPERATION_SUMMARY_BIT_SUMMARY, 1'b0, event_summary_bit, message_available_flag, QUESTIONABLE_SUMMARY_BIT_SUMMARY, 3'b000} & SERVICE_MASK);
	// Message-available flag tracks the output queue.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			message_available_flag <= 1'b0;
		end else if ((cmd && CMD_CODE == CMD_CLEAR) || OUTPUT_QUEUE_EMPTY) begin
			message_available_flag <= 1'b0;
		end else begin
			message_available_flag <= 1'b1;
		end
	end
	// Request flag set on master rise; rise beats a simultaneous poll.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mss_d <= 1'b0;
			service_requested_flag   <= 1'b0;
		end else begin
			mss_d <= master_summary_bit;
			if (master_summary_bit && !mss_d) begin
				service_requested_flag <= 1'b1;
			end else if (SERIAL_POLL || !master_summary_bit) begin
				service_requested_flag <= 1'b0;
			end
		end
	end
	assign SRQ = service_requested_flag;
	// Query answers and poll data, registered.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			QUERY_DATA  <= 8'h00;
			QUERY_VALID <= 1'b0;
			POLL_DATA   <= 8'h00;
		end else begin
			QUERY_VALID <= cmd && (CMD_CODE == CMD_STBQ || CMD_CODE == CMD_TEST);
			if (cmd && CMD_CODE == CMD_STBQ) QUERY_DATA <= stb;
			else if (cmd && CMD_CODE == CMD_TEST) QUERY_DATA <= {7'd0, SELF_TEST_FAIL};
			if (SERIAL_POLL) POLL_DATA <= {stb[7], service_requested_flag, stb[5:0]};
		end
	end
	// ************************************************************
	// Checks.
	// ************************************************************
	// Recall keeps every state bit except the calibration enable.
	localparam logic [STATE_W-1:0] keep_mask = ~(STATE_W'(1) << CAL_BIT);
	// A poll that does not meet a master summary rise in the same cycle.
	sequence s_poll;
		SERIAL_POLL && !(master_summary_bit && !mss_d);
	endsequence
	// Recall and defaults commands taken at this edge.
	sequence s_recall;
		cmd && CMD_CODE == CMD_RECALL;
	endsequence
	sequence s_defaults;
		cmd && CMD_CODE == CMD_DEFLT;
	endsequence
	// A wait just taken, and a wait whose pending work has finished.
	sequence s_wait_taken;
		cmd && CMD_CODE == CMD_WAIT;
	endsequence
	sequence s_wait_done;
		seq == S_WAIT && !PENDING_BUSY;
	endsequence
	// Mask, status byte and message flag checks.
	a_zero_mask: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(SERVICE_MASK == 8'h00) |=> !SRQ)
		else $error("service request with zero mask");
	a_mask_write: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		cmd && CMD_CODE == CMD_SRMASK |=> SERVICE_MASK == $past(CMD_ARG))
		else $error("service mask not written");
	a_mss_set: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		|(stb & SERVICE_MASK & 8'hB8) |-> stb[STB_MSS])
		else $error("enabled status bit without master summary");
	a_low_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		QUERY_VALID && $past(CMD_CODE) == CMD_STBQ |-> QUERY_DATA[2:0] == 3'b000)
		else $error("low status bits set");
	a_stbq_keep: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		cmd && CMD_CODE == CMD_STBQ && !OUTPUT_QUEUE_EMPTY |=> stb[STB_MAV])
		else $error("status query cleared a bit");
	a_stb_follow: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		stb[STB_OPERATION_SUMMARY_BIT] == OPERATION_SUMMARY_BIT_SUMMARY && stb[STB_QUESTIONABLE_SUMMARY_BIT] == QUESTIONABLE_SUMMARY_BIT_SUMMARY)
		else $error("summary bit differs from its event register");
	a_mav_clear: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(cmd && CMD_CODE == CMD_CLEAR) || OUTPUT_QUEUE_EMPTY |=> !stb[STB_MAV])
		else $error("message flag not cleared");
	a_event_sum: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		|(STD_EVENTS & ev_mask) |-> stb[STB_ESB])
		else $error("event summary missing");
	// Serial poll and service request checks.
	a_poll_data: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		SERIAL_POLL |=> POLL_DATA[6] == $past(service_requested_flag))
		else $error("poll request bit wrong");
	a_poll_rest: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		SERIAL_POLL |=> POLL_DATA[7] == $past(stb[7]) && POLL_DATA[5:0] == $past(stb[5:0]))
		else $error("poll status bits wrong");
	a_poll_clears: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_poll |=> !service_requested_flag)
		else $error("poll kept the request flag");
	a_rise_rqs: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		$rose(master_summary_bit) |=> service_requested_flag && SRQ)
		else $error("request flag not set");
	// Trigger and self-test checks.
	a_trig_gate: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		TRIGGER_PULSE |-> $past(TRIG_SOURCE_BUS))
		else $error("trigger without bus source");
	a_trig_fire: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		cmd && CMD_CODE == CMD_TRIG && TRIG_SOURCE_BUS |=> TRIGGER_PULSE)
		else $error("bus trigger lost");
	a_test_answer: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		cmd && CMD_CODE == CMD_TEST |=> QUERY_VALID && QUERY_DATA == {7'd0, $past(SELF_TEST_FAIL)}
			&& ERROR_PUSH == $past(SELF_TEST_FAIL))
		else $error("self-test answer wrong");
	// Wait and device clear checks.
	a_wait_enter: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_wait_taken |=> !CMD_READY)
		else $error("wait did not stall");
	a_wait_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		seq == S_WAIT && PENDING_BUSY && !DEVICE_CLEAR |=> !CMD_READY)
		else $error("wait left early");
	a_wait_done: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_wait_done |=> CMD_READY)
		else $error("wait kept after completion");
	a_dcl_exit: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		seq == S_WAIT && DEVICE_CLEAR |=> CMD_READY)
		else $error("device clear ignored");
	// Recall, defaults and power-on checks.
	a_recall_data: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_recall |=> (STATE_OUT & keep_mask) == ($past(slot_data) & keep_mask))
		else $error("recalled state wrong");
	a_recall_abort: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_recall |=> ABORT_PULSE)
		else $error("recall without abort");
	a_recall_cal: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_recall |=> STATE_LOAD && !STATE_OUT[CAL_BIT])
		else $error("recall left calibration on");
	a_boot_recall: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		seq == S_BOOT && POWER_ON_RECALL0 |=> STATE_LOAD && ABORT_PULSE && !STATE_OUT[CAL_BIT])
		else $error("power-on recall missing");
	a_default_load: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_defaults |=> STATE_LOAD && STATE_OUT == DEF_STATE)
		else $error("defaults not loaded");
	a_default_abort: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		s_defaults |=> ABORT_PULSE)
		else $error("defaults without abort");
	a_boot_clear: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		seq == S_BOOT && POWER_ON_CLEAR |=> SERVICE_MASK == 8'h00 && ev_mask == 8'h00)
		else $error("masks not cleared at power-on");
endmodule // common_command_status_unit

// file: ccsu_ctl_model.sv
`timescale 1ns/100ps
// Bus controller model: decoded commands, serial polls and device clear.
module ccsu_ctl_model
	import ccsu_pkg::*;
(
	input  wire logic       clk,
	output logic            cmd_valid,
	output logic [3:0]      cmd_code,
	output logic [7:0]      cmd_arg,
	output logic            serial_poll,
	output logic            device_clear
);
	// Idle levels from time zero.
	initial begin
		cmd_valid = 1'b0;
		cmd_code = CMD_NONE;
		cmd_arg = 8'h00;
		serial_poll = 1'b0;
		device_clear = 1'b0;
	end
	// Each command is one strobe held over exactly one rising edge.
	task automatic send(input logic [3:0] code, input logic [7:0] arg);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_arg = arg;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = CMD_NONE;
		cmd_arg = ~arg;
	endtask
	// One-cycle serial poll.
	task automatic poll();
		@(negedge clk);
		serial_poll = 1'b1;
		@(negedge clk);
		serial_poll = 1'b0;
	endtask
	// Device clear ends a stalled wait even while work is still pending.
	task automatic dclr();
		@(negedge clk);
		device_clear = 1'b1;
		@(negedge clk);
		device_clear = 1'b0;
	endtask
endmodule // ccsu_ctl_model

// file: common_command_status_unit_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module common_command_status_unit_tb
	import ccsu_pkg::*;
;
	logic CORE_CLK, RESET_N, CMD_VALID, CMD_READY, DEVICE_CLEAR, SERIAL_POLL, SRQ, QUERY_VALID;
	logic OPERATION_SUMMARY_BIT_SUMMARY, QUESTIONABLE_SUMMARY_BIT_SUMMARY, OUTPUT_QUEUE_EMPTY, PENDING_BUSY, TRIG_SOURCE_BUS;
	logic TRIGGER_PULSE, ABORT_PULSE, POWER_ON_RECALL0, NV_MASK_WRITE, SELF_TEST_FAIL, ERROR_PUSH;
	logic STATE_LOAD, POWER_ON_CLEAR;
	logic [3:0]         CMD_CODE;
	logic [7:0]         CMD_ARG, POLL_DATA, QUERY_DATA, STD_EVENTS, NV_SR_MASK, NV_EV_MASK, SERVICE_MASK;
	logic [STATE_W-1:0] LIVE_STATE, STATE_OUT, v;
	int                 n_fail, compares;
	common_command_status_unit uut (.CORE_CLK, .RESET_N, .CMD_VALID, .CMD_CODE, .CMD_ARG, .CMD_READY,
		.DEVICE_CLEAR, .SERIAL_POLL, .POLL_DATA, .SRQ, .QUERY_DATA, .QUERY_VALID, .OPERATION_SUMMARY_BIT_SUMMARY,
		.QUESTIONABLE_SUMMARY_BIT_SUMMARY, .STD_EVENTS, .OUTPUT_QUEUE_EMPTY, .PENDING_BUSY, .TRIG_SOURCE_BUS, .TRIGGER_PULSE,
		.ABORT_PULSE, .POWER_ON_RECALL0, .NV_SR_MASK, .NV_EV_MASK, .NV_MASK_WRITE, .SELF_TEST_FAIL,
		.ERROR_PUSH, .LIVE_STATE, .STATE_OUT, .STATE_LOAD, .SERVICE_MASK, .POWER_ON_CLEAR);
	ccsu_ctl_model ctl (.clk(CORE_CLK), .cmd_valid(CMD_VALID), .cmd_code(CMD_CODE), .cmd_arg(CMD_ARG),
		.serial_poll(SERIAL_POLL), .device_clear(DEVICE_CLEAR));
	// Clock of 8 ns period and inputs at time zero.
	initial begin
		CORE_CLK = 1'b0;
		forever #4 CORE_CLK = ~CORE_CLK;
	end
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Reset for five cycles, then let the boot cycle pass.
	task automatic rst();
		RESET_N = 1'b0;
		repeat (5) @(negedge CORE_CLK);
		RESET_N = 1'b1;
		repeat (2) @(negedge CORE_CLK);
		`CHK(CMD_READY, 1'b1)
		`CHK(SERVICE_MASK, 8'h00)
	endtask
	// Save a distinct state in every slot, then recall each with cal set.
	task automatic t_slots();
		for (int i = 0; i < NUM_SLOTS; i++) begin
			LIVE_STATE = 64'h0123_4567_89AB_CD01 + (64'(i) << 8);
			ctl.send(CMD_SAVE, 8'(i));
		end
		for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
			v = 64'h0123_4567_89AB_CD00 + (64'(i) << 8);
			ctl.send(CMD_RECALL, 8'(i));
			`CHK(STATE_OUT, v)
			`CHK({STATE_LOAD, ABORT_PULSE}, 2'b11)
		end
		ctl.send(CMD_DEFLT, 8'h00);
		`CHK(STATE_OUT, DEF_STATE)
		`CHK(ABORT_PULSE, 1'b1)
	endtask
	// Query the status byte one cycle after the command.
	task automatic query(input logic [7:0] exp);
		ctl.send(CMD_STBQ, 8'h00);
		`CHK({QUERY_VALID, QUERY_DATA}, {1'b1, exp})
	endtask
	// Layout, masking and summary behaviour of the status byte.
	task automatic t_status();
		{OPERATION_SUMMARY_BIT_SUMMARY, QUESTIONABLE_SUMMARY_BIT_SUMMARY, OUTPUT_QUEUE_EMPTY, STD_EVENTS} = {3'b110, 8'h01};
		ctl.send(CMD_EVMASK, 8'h01);
		ctl.send(CMD_SRMASK, 8'h00);
		repeat (4) @(negedge CORE_CLK);
		`CHK(SRQ, 1'b0)
		query(8'hB8);
		ctl.send(CMD_SRMASK, 8'h08);
		repeat (3) @(negedge CORE_CLK);
		query(8'hF8);
		{OPERATION_SUMMARY_BIT_SUMMARY, QUESTIONABLE_SUMMARY_BIT_SUMMARY, OUTPUT_QUEUE_EMPTY, STD_EVENTS} = {3'b001, 8'h00};
		ctl.send(CMD_SRMASK, 8'h10);
		repeat (3) @(negedge CORE_CLK);
		query(8'h00);
		OUTPUT_QUEUE_EMPTY = 1'b0;
		repeat (3) @(negedge CORE_CLK);
		`CHK(SRQ, 1'b1)
		ctl.poll();
		`CHK(POLL_DATA, 8'h50)
		`CHK(SRQ, 1'b0)
		query(8'h50);
		ctl.poll();
		`CHK(POLL_DATA, 8'h10)
		// Clear drops the message flag, so its return raises a new request.
		ctl.send(CMD_CLEAR, 8'h00);
		repeat (2) @(negedge CORE_CLK);
		`CHK(SRQ, 1'b1)
		OUTPUT_QUEUE_EMPTY = 1'b1;
	endtask
	// Bus trigger gating and self-test answers.
	task automatic t_trig_test();
		for (int i = 0; i < 2; i++) begin
			TRIG_SOURCE_BUS = 1'(i);
			ctl.send(CMD_TRIG, 8'h00);
			`CHK(TRIGGER_PULSE, 1'(i))
			SELF_TEST_FAIL = 1'(i);
			ctl.send(CMD_TEST, 8'h00);
			`CHK({QUERY_VALID, QUERY_DATA, ERROR_PUSH}, {1'b1, 8'(i), 1'(i)})
		end
	endtask
	// Power-on clear setting and the stored mask write it enables.
	task automatic t_psc();
		ctl.send(CMD_PSC, 8'h00);
		`CHK(POWER_ON_CLEAR, 1'b0)
		ctl.send(CMD_SRMASK, 8'h20);
		`CHK({SERVICE_MASK, NV_MASK_WRITE}, {8'h20, 1'b1})
		ctl.send(CMD_PSC, 8'h01);
		`CHK(POWER_ON_CLEAR, 1'b1)
		ctl.send(CMD_SRMASK, 8'h00);
		`CHK({SERVICE_MASK, NV_MASK_WRITE}, {8'h00, 1'b0})
	endtask
	// Wait stalls while work is pending; ends on completion or device clear.
	task automatic t_wait();
		for (int i = 0; i < 2; i++) begin
			PENDING_BUSY = 1'b1;
			ctl.send(CMD_WAIT, 8'h00);
			`CHK(CMD_READY, 1'b0)
			ctl.send(CMD_TRIG, 8'h00);
			`CHK(TRIGGER_PULSE, 1'b0)
			repeat (5) @(negedge CORE_CLK);
			`CHK(CMD_READY, 1'b0)
			if (i == 0) PENDING_BUSY = 1'b0;
			else ctl.dclr();
			repeat (2) @(negedge CORE_CLK);
			`CHK(CMD_READY, 1'b1)
			PENDING_BUSY = 1'b0;
		end
	endtask
	// Main sequence, ending in a power-on recall of slot 0.
	initial begin
		{n_fail, compares} = 0;
		{RESET_N, OPERATION_SUMMARY_BIT_SUMMARY, QUESTIONABLE_SUMMARY_BIT_SUMMARY, PENDING_BUSY, TRIG_SOURCE_BUS, SELF_TEST_FAIL} = 6'b000000;
		{POWER_ON_RECALL0, OUTPUT_QUEUE_EMPTY, STD_EVENTS, NV_SR_MASK, NV_EV_MASK} = {2'b01, 24'h00_5A3C};
		LIVE_STATE = DEF_STATE;
		rst();
		t_slots();
		t_status();
		t_trig_test();
		t_psc();
		t_wait();
		LIVE_STATE = 64'h1111_2222_3333_4440;
		ctl.send(CMD_SAVE, 8'h00);
		POWER_ON_RECALL0 = 1'b1;
		rst();
		`CHK(STATE_OUT, 64'h1111_2222_3333_4440)
		conclude();
	end
	// Watchdog well beyond the expected hundred or so cycles.
	initial begin
		#(8 * 4000);
		n_fail++;
		conclude();
	end
endmodule // common_command_status_unit_tb
